// File: design/tnr_output_node.sv
// receive-only output node of a token-scheduled broadcast network
//
// Contract
// - Tokens run from zero to the highest address and wrap, each one making its owner broadcast 16 bits.
// - Several nodes may share a receiver address and each accepts the same word on its own.
// - This node only receives, never transmits, and takes its receiver address from a switch.
// - A matching word is driven onto the sixteen outputs, one bit per channel.
// - All nodes run at one bit rate, standard or high speed, never mixed.
// - A communication error lights the error indicator and freezes the outputs.
// - The freeze is released when the hold-clear switch is on, which is normally off.
// - A run indicator and an error indicator show whether communication is healthy.
// - Reception and output updating are done wholly in hardware.
`include "tnr_map.svh"

module tnr_output_node #(
   parameter int unsigned SCAN_STD_CYC = `TNR_SCAN_STD_NS / `TNR_CLK_NS,
   parameter int unsigned SCAN_FST_CYC = `TNR_SCAN_FST_NS / `TNR_CLK_NS
) (
   input  wire logic              clock_i,      // 20 MHz clock
   input  wire logic              rst_b_i,      // async reset, low
   input  wire logic              line_i,       // network receive line
   input  wire logic              fast_i,       // rate strap: high speed
   input  wire logic [2:0]        rx_id_i,      // receiver_node_id switch
   input  wire logic              hold_clear_i, // hold-clear switch, on = 1
   input  wire logic [7:0]        addr_i,       // register byte address
   input  wire logic [31:0]       wdata_i,      // register write data
   input  wire logic              wr_i,         // write strobe
   input  wire logic              rd_i,         // read strobe
   output logic [31:0]            rdata_o,      // read data, next cycle
   output logic [15:0]            do_o,         // output channels
   output logic                   run_led_o,    // run indicator
   output logic                   err_led_o,    // error indicator
   output logic                   irq_o         // level interrupt
);

   ////////////////////////////////////////////////////////////////////////
   // rate strap

   logic rate_taken, next_rate_taken;
   logic fast, next_fast;

   // rate strap capture
   // caught once after reset release; a moving strap must not retime frames
   always_comb begin
      next_rate_taken = 1'b1;
      next_fast       = rate_taken ? fast : fast_i;
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rate_taken <= 1'b0;
         fast       <= 1'b0;
      end else begin
         rate_taken <= next_rate_taken;
         fast       <= next_fast;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // frame receiver

   logic               frame_ok;
   logic               frame_err;
   tnr_pkg::tnr_node_t frame_sender;
   tnr_pkg::tnr_word_t frame_data;

   tnr_frame_rx u_rx (
      .clock_i     (clock_i),
      .rst_b_i     (rst_b_i),
      .line_i      (line_i),
      .fast_i      (fast),
      .frame_ok_o  (frame_ok),
      .frame_err_o (frame_err),
      .sender_o    (frame_sender),
      .data_o      (frame_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // output hold and link health

   localparam int WDOG_W = 18;

   logic [WDOG_W-1:0] wdog, next_wdog;
   logic              seen, next_seen;
   logic              hold, next_hold;
   logic              timeout;
   logic              match;
   logic              err_event;
   logic              rel_event;
   logic              wdog_en;
   logic [15:0]       next_do;
   logic              next_run;
   logic [WDOG_W-1:0] wdog_lim;

   // watchdog limit follows the strapped rate's scan time
   always_comb begin
      wdog_lim = fast ? WDOG_W'(`TNR_WDOG_SCANS * SCAN_FST_CYC)
                      : WDOG_W'(`TNR_WDOG_SCANS * SCAN_STD_CYC);
   end

   // address match only, other receivers may match too
   assign match     = frame_ok && (frame_sender == rx_id_i);
   // a lost token stream counts as a communication error
   assign timeout   = wdog_en && seen && (wdog >= wdog_lim);
   assign err_event = frame_err || (timeout && !hold);
   assign rel_event = hold && hold_clear_i;

   // health, hold and output update
   always_comb begin
      next_wdog = wdog;
      next_seen = seen;
      next_hold = hold;
      next_do   = do_o;
      // any good frame proves the token stream alive
      if (frame_ok) begin
         next_wdog = '0;
         next_seen = 1'b1;
      end else if (wdog < wdog_lim) begin
         next_wdog = wdog + WDOG_W'(1);
      end
      // hold release
      // clear switch wins over a new error while it stays on
      if (hold_clear_i) begin
         next_hold = 1'b0;
      end else if (err_event) begin
         next_hold = 1'b1;
      end
      // outputs stay reset until the first match outside a hold
      if (match && !next_hold) begin
         next_do = frame_data;
      end
      next_run = next_seen && !next_hold && !timeout;
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wdog      <= '0;
         seen      <= 1'b0;
         hold      <= 1'b0;
         do_o      <= 16'h0000;
         run_led_o <= 1'b0;
         err_led_o <= 1'b0;
      end else begin
         wdog      <= next_wdog;
         seen      <= next_seen;
         hold      <= next_hold;
         do_o      <= next_do;
         run_led_o <= next_run;
         err_led_o <= next_hold;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register port and interrupt

   localparam int EVW = `TNR_EV_WIDTH;

   logic [EVW-1:0] status, next_status;
   logic [EVW-1:0] mask, next_mask;
   logic           ctrl_wdog, next_ctrl_wdog;
   logic [31:0]    next_rdata;
   logic           next_irq;
   logic [EVW-1:0] events;
   logic [EVW-1:0] w1c;

   // write hit on one offset
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   assign wdog_en = ctrl_wdog;

   // event vector in status layout
   always_comb begin
      events                  = '0;
      // word event mirrors the output update, so a word lost to a freeze is not reported
      events[`TNR_EV_WORD]    = match && !next_hold;
      events[`TNR_EV_ERROR]   = err_event;
      events[`TNR_EV_RELEASE] = rel_event;
   end

   // sticky status, write one to clear, a same-cycle event wins
   always_comb begin
      w1c            = (wr_i && hit(addr_i, `TNR_OFS_STATUS)) ? wdata_i[EVW-1:0] : '0;
      next_status    = (status & ~w1c) | events;
      next_mask      = mask;
      next_ctrl_wdog = ctrl_wdog;
      if (wr_i && hit(addr_i, `TNR_OFS_MASK)) begin
         next_mask = wdata_i[EVW-1:0];
      end
      if (wr_i && hit(addr_i, `TNR_OFS_CTRL)) begin
         next_ctrl_wdog = wdata_i[`TNR_CTRL_WDOG];
      end
      next_irq = |(next_status & next_mask);
   end

   // read mux, unmapped offsets read zero, data valid one cycle later
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (rd_i) begin
         case (addr_i)
            `TNR_OFS_STATUS: next_rdata[EVW-1:0] = status;
            `TNR_OFS_MASK:   next_rdata[EVW-1:0] = mask;
            `TNR_OFS_CTRL:   next_rdata[`TNR_CTRL_WDOG] = ctrl_wdog;
            `TNR_OFS_OUTPUT: next_rdata[15:0] = do_o;
            `TNR_OFS_STATE: begin
               next_rdata[`TNR_ST_RUN]  = run_led_o;
               next_rdata[`TNR_ST_ERR]  = err_led_o;
               next_rdata[`TNR_ST_FAST] = fast;
               next_rdata[`TNR_ST_ID_LSB +: `TNR_ID_W] = rx_id_i;
            end
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         status    <= '0;
         mask      <= `TNR_RST_MASK;
         ctrl_wdog <= `TNR_RST_CTRL;
         rdata_o   <= 32'h0000_0000;
         irq_o     <= 1'b0;
      end else begin
         status    <= next_status;
         mask      <= next_mask;
         ctrl_wdog <= next_ctrl_wdog;
         rdata_o   <= next_rdata;
         irq_o     <= next_irq;
      end
   end

endmodule

// File: design/tnr_map.svh
// offsets, field positions, reset values and timing counts of the receiver node
`ifndef TNR_MAP_SVH
`define TNR_MAP_SVH

// register byte offsets
`define TNR_OFS_STATUS  8'h00
`define TNR_OFS_MASK    8'h04
`define TNR_OFS_CTRL    8'h08
`define TNR_OFS_OUTPUT  8'h0C
`define TNR_OFS_STATE   8'h10

// status and mask bit positions
`define TNR_EV_WORD     0
`define TNR_EV_ERROR    1
`define TNR_EV_RELEASE  2
`define TNR_EV_WIDTH    3

// control bit positions
`define TNR_CTRL_WDOG   0

// state register bit positions
`define TNR_ST_RUN      0
`define TNR_ST_ERR      1
`define TNR_ST_FAST     2
`define TNR_ST_ID_LSB   4

// reset values
`define TNR_RST_MASK    3'h0
`define TNR_RST_CTRL    1'h1

// frame layout after the start bit
`define TNR_FRAME_BITS  21
`define TNR_ID_W        3
`define TNR_WORD_W      16

// timing, in nanoseconds, and the watchdog length in scans
`define TNR_CLK_NS      50
`define TNR_BIT_STD_NS  4000
`define TNR_BIT_FAST_NS 1000
`define TNR_SCAN_STD_NS 2880000
`define TNR_SCAN_FST_NS 720000
`define TNR_WDOG_SCANS  2

`endif

// File: design/tnr_pkg.sv
// types shared by the token network receiver node
package tnr_pkg;

   typedef logic [15:0] tnr_word_t;
   typedef logic [2:0]  tnr_node_t;

   typedef enum logic [1:0] {
      tnr_rx_idle  = 2'b00,
      tnr_rx_start = 2'b01,
      tnr_rx_bits  = 2'b10
   } tnr_rx_state_e;

endpackage

// File: design/tnr_frame_rx.sv
// serial frame deserializer: start, sender id, data word, even parity, stop
`include "tnr_map.svh"

module tnr_frame_rx (
   input  wire logic              clock_i,      // system clock
   input  wire logic              rst_b_i,      // async reset, low
   input  wire logic              line_i,       // network line, idles high
   input  wire logic              fast_i,       // high-speed bit rate
   output logic                   frame_ok_o,   // good frame pulse
   output logic                   frame_err_o,  // bad frame pulse
   output tnr_pkg::tnr_node_t     sender_o,     // sender_node_id of frame
   output tnr_pkg::tnr_word_t     data_o        // broadcast data word
);

   localparam int BIT_STD = `TNR_BIT_STD_NS / `TNR_CLK_NS;
   localparam int BIT_FST = `TNR_BIT_FAST_NS / `TNR_CLK_NS;

   // clocks per bit for the selected rate
   function automatic logic [6:0] bit_len(input logic fast);
      bit_len = fast ? 7'(BIT_FST) : 7'(BIT_STD);
   endfunction

   tnr_pkg::tnr_rx_state_e        state, next_state;
   logic [6:0]                    tick, next_tick;
   logic [4:0]                    bitn, next_bitn;
   logic [`TNR_FRAME_BITS-1:0]    shreg, next_shreg;
   logic                          next_ok, next_err;
   tnr_pkg::tnr_node_t            next_sender;
   tnr_pkg::tnr_word_t            next_data;

   // mid-bit sampling; a start glitch shorter than half a bit is dropped
   always_comb begin
      next_state  = state;
      next_tick   = tick;
      next_bitn   = bitn;
      next_shreg  = shreg;
      next_ok     = 1'b0;
      next_err    = 1'b0;
      next_sender = sender_o;
      next_data   = data_o;
      case (state)
         tnr_pkg::tnr_rx_idle: begin
            if (!line_i) begin
               next_state = tnr_pkg::tnr_rx_start;
               next_tick  = (bit_len(fast_i) >> 1) - 7'h01;
            end
         end
         tnr_pkg::tnr_rx_start: begin
            if (tick != 7'h00) begin
               next_tick = tick - 7'h01;
            end else if (!line_i) begin
               next_state = tnr_pkg::tnr_rx_bits;
               next_tick  = bit_len(fast_i) - 7'h01;
               next_bitn  = 5'h00;
            end else begin
               next_state = tnr_pkg::tnr_rx_idle;
            end
         end
         tnr_pkg::tnr_rx_bits: begin
            if (tick != 7'h00) begin
               next_tick = tick - 7'h01;
            end else begin
               next_shreg = {line_i, shreg[`TNR_FRAME_BITS-1:1]};
               next_tick  = bit_len(fast_i) - 7'h01;
               next_bitn  = bitn + 5'h01;
               if (bitn == 5'(`TNR_FRAME_BITS - 1)) begin
                  next_state = tnr_pkg::tnr_rx_idle;
                  // stop must be high, parity over id, data and parity even
                  if (next_shreg[20] && !(^next_shreg[19:0])) begin
                     next_ok     = 1'b1;
                     next_sender = next_shreg[2:0];
                     next_data   = next_shreg[18:3];
                  end else begin
                     next_err = 1'b1;
                  end
               end
            end
         end
         default: next_state = tnr_pkg::tnr_rx_idle;
      endcase
   end

   // register stage
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state       <= tnr_pkg::tnr_rx_idle;
         tick        <= 7'h00;
         bitn        <= 5'h00;
         shreg       <= '0;
         frame_ok_o  <= 1'b0;
         frame_err_o <= 1'b0;
         sender_o    <= 3'h0;
         data_o      <= 16'h0000;
      end else begin
         state       <= next_state;
         tick        <= next_tick;
         bitn        <= next_bitn;
         shreg       <= next_shreg;
         frame_ok_o  <= next_ok;
         frame_err_o <= next_err;
         sender_o    <= next_sender;
         data_o      <= next_data;
      end
   end

endmodule

// File: bench/tnr_output_node_asserts.sv
// port-level checks of the receiver node
module tnr_output_node_asserts #(
   parameter int unsigned SCAN_STD_CYC = 200,
   parameter int unsigned SCAN_FST_CYC = 60
) (
   input wire logic        clock_i,      // clock
   input wire logic        rst_b_i,      // reset, low
   input wire logic        line_i,       // network line
   input wire logic        fast_i,       // rate strap
   input wire logic [2:0]  rx_id_i,      // id switch
   input wire logic        hold_clear_i, // clear switch
   input wire logic [7:0]  addr_i,       // address
   input wire logic [31:0] wdata_i,      // write data
   input wire logic        wr_i,         // write strobe
   input wire logic        rd_i,         // read strobe
   input wire logic [31:0] rdata_o,      // read data
   input wire logic [15:0] do_o,         // channels
   input wire logic        run_led_o,    // run led
   input wire logic        err_led_o,    // error led
   input wire logic        irq_o         // interrupt
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   ////////////////////////////////////////////////////////////////////////////////
   // register reads and switch sequences
   sequence s_read_out;
      rd_i && addr_i == 8'h0C;
   endsequence
   sequence s_read_state;
      rd_i && addr_i == 8'h10;
   endsequence
   sequence s_clear_held;
      hold_clear_i [*3];
   endsequence

   ////////////////////////////////////////////////////////////////////////////////
   chk_reset_quiet: assert property (
      $rose(rst_b_i) |-> do_o == 16'h0000 && !run_led_o && !err_led_o)
      else $error("outputs not quiet after reset");
   chk_out_read: assert property (
      s_read_out |=> rdata_o == {16'h0000, $past(do_o)})
      else $error("output register differs from channels");
   chk_state_read: assert property (
      s_read_state |=> rdata_o[6:4] == $past(rx_id_i)
         && rdata_o[1:0] == {$past(err_led_o), $past(run_led_o)})
      else $error("state register differs from pins");
   chk_rdata_idle: assert property (
      !rd_i |=> rdata_o == 32'h0000_0000)
      else $error("read data outside its cycle");
   chk_frozen_hold: assert property (
      err_led_o && !hold_clear_i |=> $stable(do_o))
      else $error("channels moved while frozen");
   chk_led_excl: assert property (
      err_led_o |-> !run_led_o)
      else $error("run and error lit together");
   chk_change_healthy: assert property (
      $changed(do_o) |-> run_led_o && !err_led_o)
      else $error("channels changed without healthy link");
   chk_clear_release: assert property (
      s_clear_held |-> !err_led_o)
      else $error("hold not released by clear switch");
endmodule

// File: bench/tnr_net_model.sv
// token network model: manager scan and frame sender
module tnr_net_model #(
   parameter int BIT_FST = 20, // clocks per bit, high speed
   parameter int BIT_STD = 80  // clocks per bit, standard
) (
   input  wire logic clock_i, // clock
   input  wire logic fast_i,  // network runs high speed
   output logic      line_o   // network line
);
   timeunit 1ns;
   timeprecision 1ps;
   // line idles high, as a biased differential pair does
   initial line_o = 1'b1;

   task automatic send_frame(input logic [2:0] id, input logic [15:0] d, input logic bad);
      logic [21:0] f;
      f = {1'b1, (^{d, id}) ^ bad, d, id, 1'b0};
      @(posedge clock_i);
      for (int i = 0; i < 22; i++) begin
         line_o <= f[i];
         repeat (fast_i ? BIT_FST : BIT_STD) @(posedge clock_i);
      end
   endtask

   // one scan, each id once in order
   task automatic scan();
      for (int i = 0; i < 8; i++) begin
         send_frame(3'(i), 16'hA5C0 | 16'(i), 1'b0);
      end
   endtask
endmodule

// File: bench/tnr_output_node_tb.sv
// self-checking bench of the receiver node
module tnr_output_node_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned FST = 800; // short scan keeps the run brief
   logic        clock_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic        line_i;
   logic        fast_i = 1'b1;
   logic [2:0]  rx_id_i = 3'h3;
   logic        hold_clear_i = 1'b0;
   logic [7:0]  addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0000_0000;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic [31:0] rdata_o;
   logic [15:0] do_o;
   logic        run_led_o;
   logic        err_led_o;
   logic        irq_o;
   int          num_errors = 0;
   int          check_count = 0;

   // 20 MHz clock
   always #25 clock_i = ~clock_i;

   tnr_output_node #(.SCAN_STD_CYC(2000), .SCAN_FST_CYC(FST)) DUT (
      .clock_i(clock_i), .rst_b_i(rst_b_i), .line_i(line_i), .fast_i(fast_i),
      .rx_id_i(rx_id_i), .hold_clear_i(hold_clear_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .do_o(do_o),
      .run_led_o(run_led_o), .err_led_o(err_led_o), .irq_o(irq_o));
   tnr_net_model #(.BIT_FST(20), .BIT_STD(80)) net (
      .clock_i(clock_i), .fast_i(fast_i), .line_o(line_i));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask
   // read data are valid only in the cycle after the strobe
   task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
      @(posedge clock_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 check(n, e, rdata_o);
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // hang guard, well above the expected 9k cycles
   initial begin
      repeat (60000) @(posedge clock_i);
      num_errors++;
      wrap_up();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (5) @(posedge clock_i);
      rst_b_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      check("do_o", 32'h0, {16'h0, do_o});
      rd_chk("ctrl", 8'h08, 32'h0000_0001);
      rd_chk("mask", 8'h04, 32'h0000_0000);
      $display("test reset done");
      wr_reg(8'h04, 32'h0000_0007);
      net.scan();
      check("do_o", 32'hA5C3, {16'h0, do_o});
      check("run", 32'h1, {31'h0, run_led_o});
      check("irq", 32'h1, {31'h0, irq_o});
      rd_chk("status", 8'h00, 32'h0000_0001);
      wr_reg(8'h00, 32'h0000_0001);
      rd_chk("status", 8'h00, 32'h0000_0000);
      check("irq", 32'h0, {31'h0, irq_o});
      $display("test scan done");
      @(posedge clock_i);
      rx_id_i <= 3'h5;
      net.send_frame(3'h5, 16'h0F0F, 1'b0);
      net.send_frame(3'h3, 16'hFFFF, 1'b0);
      check("do_o", 32'h0F0F, {16'h0, do_o});
      $display("test address done");
      net.send_frame(3'h5, 16'h1234, 1'b1);
      check("err", 32'h1, {31'h0, err_led_o});
      net.send_frame(3'h5, 16'h5678, 1'b0);
      check("do_o", 32'h0F0F, {16'h0, do_o});
      rd_chk("state", 8'h10, 32'h0000_0056);
      rd_chk("status", 8'h00, 32'h0000_0003);
      check("irq", 32'h1, {31'h0, irq_o});
      $display("test error done");
      @(posedge clock_i);
      hold_clear_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      hold_clear_i <= 1'b0;
      @(posedge clock_i);
      check("err", 32'h0, {31'h0, err_led_o});
      rd_chk("status", 8'h00, 32'h0000_0007);
      wr_reg(8'h00, 32'h0000_0007);
      net.send_frame(3'h5, 16'h5678, 1'b0);
      check("do_o", 32'h5678, {16'h0, do_o});
      $display("test release done");
      repeat (2 * FST + 100) @(posedge clock_i);
      check("err", 32'h1, {31'h0, err_led_o});
      check("run", 32'h0, {31'h0, run_led_o});
      wr_reg(8'h0C, 32'h0000_FFFF);
      rd_chk("output", 8'h0C, 32'h0000_5678);
      rd_chk("unmapped", 8'h20, 32'h0000_0000);
      $display("test timeout done");
      // second reset in mid-run, strap now at standard rate
      @(posedge clock_i);
      rst_b_i <= 1'b0;
      fast_i <= 1'b0;
      repeat (5) @(posedge clock_i);
      rst_b_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      check("err", 32'h0, {31'h0, err_led_o});
      check("do_o", 32'h0, {16'h0, do_o});
      rd_chk("state", 8'h10, 32'h0000_0050);
      net.send_frame(3'h5, 16'hC33C, 1'b0);
      check("do_o", 32'hC33C, {16'h0, do_o});
      rd_chk("state", 8'h10, 32'h0000_0051);
      $display("test standard rate done");
      wrap_up();
   end
endmodule

bind tnr_output_node tnr_output_node_asserts #(
   .SCAN_STD_CYC(SCAN_STD_CYC), .SCAN_FST_CYC(SCAN_FST_CYC)
) u_chk (
   .clock_i(clock_i), .rst_b_i(rst_b_i), .line_i(line_i), .fast_i(fast_i),
   .rx_id_i(rx_id_i), .hold_clear_i(hold_clear_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .do_o(do_o),
   .run_led_o(run_led_o), .err_led_o(err_led_o), .irq_o(irq_o));
